// ---- inc/adcij_pkg.sv ----
// Package of constants for the ADC channel injection controller
package adcij_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ADCIJ_CTRL_OFS   = 12'h000;
  localparam logic [11:0] ADCIJ_STAT_OFS   = 12'h004;
  localparam logic [11:0] ADCIJ_MASK_OFS   = 12'h008;
  localparam logic [11:0] ADCIJ_STDRES_OFS = 12'h00C;
  localparam logic [11:0] ADCIJ_ALTRES_OFS = 12'h010;
  localparam logic [11:0] ADCIJ_INJ_OFS    = 12'h014;
  localparam logic [11:0] ADCIJ_STATE_OFS  = 12'h018;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_WFR_BIT   = 1;
  localparam int CTRL_CONT_BIT  = 2;
  localparam int CTRL_SCAN_BIT  = 3;
  localparam int CTRL_CH_LSB    = 8;
  localparam int CTRL_TRGCH_LSB = 16;
  localparam int STAT_STD_BIT   = 0;
  localparam int STAT_INJ_BIT   = 1;
  localparam int STAT_OVR_BIT   = 2;
  localparam int NUM_EVENTS     = 3;

  localparam int CH_W  = 5;
  localparam int RES_W = 10;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [2:0]  MASK_RST = 3'h0;
  localparam logic [4:0]  NUM_CH   = 5'h18;
  localparam int CLK_HZ       = 10_000_000;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYC     = (CONV_TIME_NS * (CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  localparam logic [7:0] CONV_CYC_W = 8'(CONV_CYC);

  typedef enum logic [1:0] {ADCIJ_IDLE, ADCIJ_CONV, ADCIJ_HOLD} adcij_st_e;

endpackage

// ---- rtl/adcij_conv.sv ----
// Conversion timer producing a result per started channel
`timescale 1ns/1ns
module adcij_conv
  import adcij_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [CH_W-1:0]  ch,
  input  wire logic [RES_W-1:0] sample,
  output logic                  done,
  output logic [RES_W-1:0]      result
);

  logic [7:0]       cnt_q, cnt_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;
  logic [RES_W-1:0] res_q, res_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    res_d  = res_q;
    if (start && !busy_q)
    begin
      busy_d = 1'b1;
      cnt_d  = CONV_CYC_W;
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        // Channel number folded in so results are traceable
        res_d  = sample ^ {{(RES_W-CH_W){1'b0}}, ch};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      res_q  <= '0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end

  assign done   = done_q;
  assign result = res_q;

endmodule // adcij_conv

// ---- rtl/adcij_top.sv ----
// ADC channel injection controller with APB register slave
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Injection converts one channel, mode untouched
// - Injection served with wait-for-read mode on or off
// - Injected result to alternate register, flag set
// - Occupied holding register suspends next conversion
// - Injection result waits in holding register
// - Alternate read moves held value, reflags
// - No permanent stall on early injection
// - Double alternate read releases a stall
// - Toggling wait-for-read mode unlocks converter
// - Capture_compare_unit trigger and event-transfer reads
module adcij_top
  import adcij_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic             CAPTURE_COMPARE_UNIT_INJECTION_TRIGGER,
  input  wire logic             EVENT_TRANSFER_READ,
  input  wire logic [RES_W-1:0] ANALOG_SAMPLE,
  output logic                  INJECTION_DONE_INTERRUPT,
  output logic                  EVENT_TRANSFER_REQ
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] trg_sync_q;
  logic [1:0] etr_sync_q;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      trg_sync_q <= 3'h0;
      etr_sync_q <= 2'h0;
    end
    else
    begin
      trg_sync_q <= {trg_sync_q[1:0], CAPTURE_COMPARE_UNIT_INJECTION_TRIGGER};
      etr_sync_q <= {etr_sync_q[0], EVENT_TRANSFER_READ};
    end
  end

  logic trg_rise;
  assign trg_rise = trg_sync_q[1] & ~trg_sync_q[2];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic acc, wr, rd, rd_setup;
  assign acc = PSEL & PENABLE;
  assign wr  = acc & PWRITE;
  assign rd  = acc & ~PWRITE;
  // Read data latched at setup so it stands together with PREADY
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

  logic known;
  always_comb
  begin
    case (PADDR)
      ADCIJ_CTRL_OFS, ADCIJ_STAT_OFS, ADCIJ_MASK_OFS, ADCIJ_STDRES_OFS,
      ADCIJ_ALTRES_OFS, ADCIJ_INJ_OFS, ADCIJ_STATE_OFS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Event-transfer read counts as an alternate result read
  logic alt_rd;
  assign alt_rd = (rd & (PADDR == ADCIJ_ALTRES_OFS)) | etr_sync_q[1];

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  adcij_st_e        st_q, st_d;
  logic [31:0]      ctrl_q, ctrl_d;
  logic [2:0]       stat_q, stat_d, mask_q, mask_d;
  logic             inj_pend_q, inj_pend_d;
  logic [CH_W-1:0]  inj_ch_q, inj_ch_d;
  logic [CH_W-1:0]  scan_ch_q, scan_ch_d;
  logic             cur_inj_q, cur_inj_d;
  logic             std_once_q, std_once_d;
  logic [RES_W-1:0] std_res_q, std_res_d, alt_res_q, alt_res_d;
  logic [RES_W-1:0] hold_q, hold_d;
  logic             hold_full_q, hold_full_d, hold_inj_q, hold_inj_d;
  logic             alt_unread_q, alt_unread_d;
  logic             std_unread_q, std_unread_d;
  logic [31:0]      prdata_d;
  logic             irq_q, irq_d, etreq_q, etreq_d;

  logic             conv_done, conv_start;
  logic [RES_W-1:0] conv_res;
  logic [CH_W-1:0]  conv_ch;
  logic [2:0]       ev;

  adcij_conv u_conv (
    .clk    (CLK),
    .rst    (SYS_RST),
    .start  (conv_start),
    .ch     (conv_ch),
    .sample (ANALOG_SAMPLE),
    .done   (conv_done),
    .result (conv_res)
  );

  assign conv_start = (st_q == ADCIJ_CONV);
  assign conv_ch    = cur_inj_q ? inj_ch_q : scan_ch_q;

  always_comb
  begin
    st_d         = st_q;
    ctrl_d       = ctrl_q;
    mask_d       = mask_q;
    inj_pend_d   = inj_pend_q;
    inj_ch_d     = inj_ch_q;
    scan_ch_d    = scan_ch_q;
    cur_inj_d    = cur_inj_q;
    std_once_d   = std_once_q;
    std_res_d    = std_res_q;
    alt_res_d    = alt_res_q;
    hold_d       = hold_q;
    hold_full_d  = hold_full_q;
    hold_inj_d   = hold_inj_q;
    alt_unread_d = alt_unread_q;
    std_unread_d = std_unread_q;
    ev           = 3'h0;

    // Register writes
    if (wr && PADDR == ADCIJ_CTRL_OFS)
    begin
      ctrl_d = PWDATA;
      // Leaving wait-for-read drops held data, unlocks converter
      if (!PWDATA[CTRL_WFR_BIT] && ctrl_q[CTRL_WFR_BIT])
      begin
        hold_full_d  = 1'b0;
        alt_unread_d = 1'b0;
        std_unread_d = 1'b0;
      end
      if (PWDATA[CTRL_EN_BIT] && !ctrl_q[CTRL_EN_BIT])
        std_once_d = 1'b1;
    end
    if (wr && PADDR == ADCIJ_MASK_OFS)
      mask_d = PWDATA[NUM_EVENTS-1:0];
    if (wr && PADDR == ADCIJ_INJ_OFS && !inj_pend_q)
    begin
      inj_pend_d = 1'b1;
      inj_ch_d   = PWDATA[CH_W-1:0];
    end
    if (trg_rise && !inj_pend_q)
    begin
      inj_pend_d = 1'b1;
      inj_ch_d   = ctrl_q[CTRL_TRGCH_LSB +: CH_W];
    end
    if (rd && PADDR == ADCIJ_STDRES_OFS)
      std_unread_d = 1'b0;

    // Alternate read: held value moves up and is flagged again
    if (alt_rd)
    begin
      if (hold_full_q && hold_inj_q)
      begin
        alt_res_d    = hold_q;
        hold_full_d  = 1'b0;
        alt_unread_d = 1'b1;
        ev[STAT_INJ_BIT] = 1'b1;
      end
      else
        alt_unread_d = 1'b0;
    end
    if (rd && PADDR == ADCIJ_STDRES_OFS && hold_full_q && !hold_inj_q)
    begin
      std_res_d    = hold_q;
      hold_full_d  = 1'b0;
      std_unread_d = 1'b1;
      ev[STAT_STD_BIT] = 1'b1;
    end

    case (st_q)
      ADCIJ_IDLE:
      begin
        // Suspended while holding register is occupied
        if (!hold_full_q && ctrl_q[CTRL_EN_BIT])
        begin
          if (inj_pend_q)
          begin
            cur_inj_d = 1'b1;
            st_d      = ADCIJ_CONV;
          end
          else if (ctrl_q[CTRL_CONT_BIT] || std_once_q)
          begin
            cur_inj_d  = 1'b0;
            std_once_d = 1'b0;
            st_d       = ADCIJ_CONV;
          end
        end
      end
      ADCIJ_CONV:
        st_d = ADCIJ_HOLD;
      ADCIJ_HOLD:
      begin
        if (conv_done)
        begin
          st_d = ADCIJ_IDLE;
          if (cur_inj_q)
          begin
            inj_pend_d = 1'b0;
            if (alt_unread_d && ctrl_q[CTRL_WFR_BIT])
            begin
              hold_d      = conv_res;
              hold_full_d = 1'b1;
              hold_inj_d  = 1'b1;
            end
            else
            begin
              alt_res_d    = conv_res;
              alt_unread_d = 1'b1;
              ev[STAT_INJ_BIT] = 1'b1;
            end
          end
          else
          begin
            if (ctrl_q[CTRL_SCAN_BIT])
              scan_ch_d = (scan_ch_q == CH_W'(NUM_CH - 5'h01)) ?
                          '0 : scan_ch_q + CH_W'(1);
            else
              scan_ch_d = ctrl_q[CTRL_CH_LSB +: CH_W];
            if (std_unread_d && ctrl_q[CTRL_WFR_BIT])
            begin
              hold_d      = conv_res;
              hold_full_d = 1'b1;
              hold_inj_d  = 1'b0;
            end
            else
            begin
              if (std_unread_d)
                ev[STAT_OVR_BIT] = 1'b1;
              std_res_d    = conv_res;
              std_unread_d = 1'b1;
              ev[STAT_STD_BIT] = 1'b1;
            end
          end
        end
      end
      default:
        st_d = ADCIJ_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Sticky status, mask, interrupt and read data
  // ---------------------------------------------------------------
  always_comb
  begin
    stat_d = stat_q;
    if (wr && PADDR == ADCIJ_STAT_OFS)
      stat_d = stat_q & ~PWDATA[NUM_EVENTS-1:0];
    stat_d = stat_d | ev; // Set wins over clear
    irq_d   = |(stat_d & mask_q);
    etreq_d = stat_d[STAT_INJ_BIT];
    prdata_d = 32'h0000_0000;
    if (rd_setup)
    begin
      case (PADDR)
        ADCIJ_CTRL_OFS:   prdata_d = ctrl_q;
        ADCIJ_STAT_OFS:   prdata_d = {29'h0, stat_q};
        ADCIJ_MASK_OFS:   prdata_d = {29'h0, mask_q};
        ADCIJ_STDRES_OFS: prdata_d = {22'h0, std_res_q};
        ADCIJ_ALTRES_OFS: prdata_d = {22'h0, alt_res_q};
        ADCIJ_INJ_OFS:    prdata_d = {26'h0, inj_pend_q, inj_ch_q};
        ADCIJ_STATE_OFS:  prdata_d = {26'h0, hold_full_q, hold_inj_q,
                                      alt_unread_q, std_unread_q,
                                      st_q};
        default:          prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q         <= ADCIJ_IDLE;
      ctrl_q       <= CTRL_RST;
      stat_q       <= 3'h0;
      mask_q       <= MASK_RST;
      inj_pend_q   <= 1'b0;
      inj_ch_q     <= '0;
      scan_ch_q    <= '0;
      cur_inj_q    <= 1'b0;
      std_once_q   <= 1'b0;
      std_res_q    <= '0;
      alt_res_q    <= '0;
      hold_q       <= '0;
      hold_full_q  <= 1'b0;
      hold_inj_q   <= 1'b0;
      alt_unread_q <= 1'b0;
      std_unread_q <= 1'b0;
      irq_q        <= 1'b0;
      etreq_q      <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;
      ctrl_q       <= ctrl_d;
      stat_q       <= stat_d;
      mask_q       <= mask_d;
      inj_pend_q   <= inj_pend_d;
      inj_ch_q     <= inj_ch_d;
      scan_ch_q    <= scan_ch_d;
      cur_inj_q    <= cur_inj_d;
      std_once_q   <= std_once_d;
      std_res_q    <= std_res_d;
      alt_res_q    <= alt_res_d;
      hold_q       <= hold_d;
      hold_full_q  <= hold_full_d;
      hold_inj_q   <= hold_inj_d;
      alt_unread_q <= alt_unread_d;
      std_unread_q <= std_unread_d;
      irq_q        <= irq_d;
      etreq_q      <= etreq_d;
    end
  end

  // Zero wait state; read data registered alongside
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      INJECTION_DONE_INTERRUPT <= 1'b0;
      EVENT_TRANSFER_REQ       <= 1'b0;
    end
    else
    begin
      PRDATA  <= prdata_d;
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~known;
      INJECTION_DONE_INTERRUPT <= irq_d;
      EVENT_TRANSFER_REQ       <= etreq_d;
    end
  end

endmodule // adcij_top

// ---- verif/adcij_chk.sv ----
// Checker of port relations for the injection controller
`timescale 1ns/1ns
module adcij_chk
  import adcij_pkg::*;
(
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        INJECTION_DONE_INTERRUPT,
  input wire logic        EVENT_TRANSFER_REQ
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic acc;
  logic clr;
  assign acc = PSEL && PENABLE;
  // Only a write-one-to-clear of the status word may drop the request
  assign clr = acc && PWRITE && (PADDR == ADCIJ_STAT_OFS);
  rdy_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No ready after setup");
  rdy_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("Ready without setup");
  rdy_single_a: assert property (PREADY |=> !PREADY)
    else $error("Ready held two cycles");
  err_with_rdy_a: assert property (PSLVERR |-> PREADY)
    else $error("Error without ready");
  err_data_zero_a: assert property (PSLVERR && !PWRITE |-> !(|PRDATA))
    else $error("Error read returned data");
  unmap_err_a: assert property
    (acc && (PADDR > 12'h018 || PADDR[1:0] != 2'b00) |-> PSLVERR)
    else $error("Unmapped access not refused");
  map_ok_a: assert property
    (acc && PADDR <= 12'h018 && PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("Mapped access refused");
  req_sticky_a: assert property
    ($fell(EVENT_TRANSFER_REQ) |-> $past(clr) || $past(clr, 2))
    else $error("Done request dropped without clear");
  cover property ($rose(EVENT_TRANSFER_REQ));
  cover property ($rose(INJECTION_DONE_INTERRUPT));
  cover property (PSLVERR);
endmodule // adcij_chk

bind adcij_top adcij_chk adcij_chk_inst (.CLK, .SYS_RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .INJECTION_DONE_INTERRUPT,
  .EVENT_TRANSFER_REQ);

// ---- verif/adcij_evt_model.sv ----
// Event transfer controller model fetching injected results
`timescale 1ns/1ns
module adcij_evt_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic       req,
  output logic            rd,
  output logic [7:0]      cnt
);
  logic req_q;
  // One fetch per new request; a request seen while blocked is lost
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      req_q <= 1'b0;
      rd    <= 1'b0;
      cnt   <= 8'h00;
    end
    else
    begin
      req_q <= req;
      rd    <= en && req && !req_q;
      cnt   <= cnt + 8'(en && req && !req_q);
    end
endmodule // adcij_evt_model

// ---- verif/tb_top.sv ----
// Self-checking testbench of the injection controller
`timescale 1ns/1ns
module tb_top;
  import adcij_pkg::*;
  logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
  logic PREADY, PSLVERR, IRQ, REQ, TRG = 0, RD, EN = 0, e;
  logic [RES_W-1:0] SMP = 10'h2A5;
  logic [7:0] cnt;
  int miscompares = 0, n_tests = 0;
  always #50 CLK = ~CLK;
  adcij_top adcij_top_inst (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CAPTURE_COMPARE_UNIT_INJECTION_TRIGGER(TRG), .EVENT_TRANSFER_READ(RD),
    .ANALOG_SAMPLE(SMP), .INJECTION_DONE_INTERRUPT(IRQ),
    .EVENT_TRANSFER_REQ(REQ));
  adcij_evt_model adcij_evt_model_inst (.clk(CLK), .rst(SYS_RST), .en(EN),
    .req(REQ), .rd(RD), .cnt(cnt));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      miscompares++;
    end
  endtask
  task automatic stop_on(input int n);
    if (n >= 200)
    begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 200)
    begin
      @(posedge CLK);
      n++;
    end
    stop_on(n);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  function automatic logic [31:0] res(input logic [4:0] c);
    return {22'h0, SMP ^ {5'h00, c}};
  endfunction
  task automatic wait_req;
    int n;
    n = 0;
    @(negedge CLK);
    while (REQ !== 1'b1 && n < 200)
    begin
      @(negedge CLK);
      n++;
    end
    stop_on(n);
    @(posedge CLK);
  endtask
  task automatic inject(input logic [4:0] c, input logic clr);
    apb(1'b1, ADCIJ_INJ_OFS, {27'h0, c});
    wait_req();
    if (clr)
      apb(1'b1, ADCIJ_STAT_OFS, 32'h0000_0002);
  endtask
  task automatic wait_held;
    int n;
    n = 0;
    r = 32'h0000_0000;
    while (r[5] !== 1'b1 && n < 200)
    begin
      apb(1'b0, ADCIJ_STATE_OFS, 32'h0000_0000);
      n++;
    end
    stop_on(n);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, ADCIJ_CTRL_OFS, 32'h0000_0000);
    chk(r, CTRL_RST);
    apb(1'b0, ADCIJ_MASK_OFS, 32'h0000_0000);
    chk(r, 32'(MASK_RST));
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk({r[30:0], e}, 32'h0000_0001);
    // Converter must be enabled before any injection is served
    apb(1'b1, ADCIJ_CTRL_OFS, CTRL_RST | 32'h0000_0001);
    $display("t_reset done");
  endtask
  task automatic t_sw_inject;
    apb(1'b1, ADCIJ_MASK_OFS, 32'h0000_0002);
    inject(5'h05, 1'b0);
    @(negedge CLK);
    chk(IRQ, 1'b1);
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h05));
    apb(1'b1, ADCIJ_STAT_OFS, 32'h0000_0002);
    @(negedge CLK);
    chk({IRQ, REQ}, 2'b00);
    apb(1'b0, ADCIJ_CTRL_OFS, 32'h0000_0000);
    chk(r, CTRL_RST | 32'h0000_0001);
    $display("t_sw_inject done");
  endtask
  task automatic t_double;
    inject(5'h03, 1'b1);
    apb(1'b1, ADCIJ_INJ_OFS, 32'h0000_0007);
    wait_held();
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h03));
    wait_req();
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h07));
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    apb(1'b1, ADCIJ_STAT_OFS, 32'h0000_0002);
    inject(5'h01, 1'b1);
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h01));
    $display("t_double done");
  endtask
  task automatic t_capture_compare_unit;
    int n;
    n = 0;
    EN <= 1'b1;
    apb(1'b1, ADCIJ_CTRL_OFS, CTRL_RST | 32'h0009_0001);
    TRG <= 1'b1;
    wait_req();
    TRG <= 1'b0;
    while (cnt !== 8'h01 && n < 200)
    begin
      @(posedge CLK);
      n++;
    end
    stop_on(n);
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h09));
    apb(1'b1, ADCIJ_STAT_OFS, 32'h0000_0002);
    EN <= 1'b0;
    $display("t_capture_compare_unit done");
  endtask
  task automatic t_unlock;
    inject(5'h04, 1'b1);
    apb(1'b1, ADCIJ_INJ_OFS, 32'h0000_0006);
    wait_held();
    apb(1'b1, ADCIJ_CTRL_OFS, 32'h0000_0001);
    apb(1'b1, ADCIJ_CTRL_OFS, CTRL_RST | 32'h0000_0001);
    apb(1'b0, ADCIJ_STATE_OFS, 32'h0000_0000);
    chk(r[5], 1'b0);
    apb(1'b1, ADCIJ_STAT_OFS, 32'h0000_0007);
    inject(5'h08, 1'b0);
    apb(1'b0, ADCIJ_ALTRES_OFS, 32'h0000_0000);
    chk(r, res(5'h08));
    $display("t_unlock done");
  endtask
  initial
  begin
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_sw_inject();
    t_double();
    t_capture_compare_unit();
    t_unlock();
    final_report();
  end
endmodule // tb_top
